// ---- verilog/ddrdp_port.sv ----
// Purpose: Data-side pin logic of a two-word-burst DDR SRAM: load, beats, masks.
// Assumes: k_rise_i / kn_rise_i mark K and K-bar rising edges in clk_i;
//          c_rise_i / cn_rise_i likewise for C and C-bar.
// Notes:   Write beats leave through a FIFO towards the array; read words
//          arrive from the array and are launched on the selected strobes.
`timescale 1ns/1ps
module ddrdp_port #(
  parameter int unsigned DATA_W = 36,
  parameter int unsigned ADDR_W = ddrdp_pkg::ADDR_W,
  parameter int unsigned DEPTH  = ddrdp_pkg::FIFO_DEPTH
) (
  input  wire logic                                   clk_i,
  input  wire logic                                   nrst_i,
  input  wire logic                                   k_rise_i,
  input  wire logic                                   kn_rise_i,
  input  wire logic                                   c_rise_i,
  input  wire logic                                   cn_rise_i,
  input  wire logic                                   single_clk_i,
  input  wire logic                                   cycle_load_n_i,
  input  wire logic                                   read_nwrite_i,
  input  wire logic [ADDR_W-1:0]                      addr_i,
  input  wire logic                                   nibble_sel_n0_i,
  input  wire logic                                   nibble_sel_n1_i,
  input  wire logic                                   byte_sel_n0_i,
  input  wire logic                                   byte_sel_n1_i,
  input  wire logic                                   byte_sel_n2_i,
  input  wire logic                                   byte_sel_n3_i,
  input  wire logic [DATA_W-1:0]                      dq_in_i,
  output logic      [DATA_W-1:0]                      dq_out_o,
  output logic                                        dq_oe_o,
  output logic                                        wr_valid_o,
  input  wire logic                                   wr_ready_i,
  output logic      [ADDR_W-1:0]                      wr_addr_o,
  output logic      [DATA_W-1:0]                      wr_data_o,
  output logic      [DATA_W-1:0]                      wr_bit_en_o,
  output logic                                        rd_req_o,
  output logic      [ADDR_W-1:0]                      rd_addr_o,
  input  wire logic [DATA_W-1:0]                      rd_data_i,
  output logic                                        busy_o
);
  localparam int unsigned MW = ddrdp_pkg::MAX_W;
  localparam int unsigned AW = ddrdp_pkg::ADDR_W;
  localparam int unsigned BW = AW + 2 * MW;

  typedef struct packed {
    ddrdp_pkg::ddrdp_phase_e phase;
    logic                    beat;
    logic [ADDR_W-1:0]       addr;
    logic [DATA_W-1:0]       dq_out;
    logic                    dq_oe;
    logic                    rd_req;
    logic [ADDR_W-1:0]       rd_addr;
  } ddrdp_port_s;

  ddrdp_port_s             st_ff;
  ddrdp_port_s             nxt_st;
  ddrdp_pkg::ddrdp_cmd_s   cmd;
  ddrdp_pkg::ddrdp_wbeat_s fifo_out;
  logic                    fifo_ready;
  logic                    fifo_valid;
  logic                    launch;
  logic                    capture;
  logic                    wr_push;
  ddrdp_pkg::ddrdp_wbeat_s wr_beat;

  // Builds the per-bit write enable for one beat from the active-low selects.
  function automatic logic [MW-1:0] beat_mask(input logic       n0,
                                              input logic       n1,
                                              input logic [3:0] bsel_n);
    logic [MW-1:0] m;
    m = '0;
    if (DATA_W == ddrdp_pkg::X8_W) begin
      for (int i = 0; i < ddrdp_pkg::NUM_NIBS; i++) begin
        m[i*ddrdp_pkg::NIB_W +: ddrdp_pkg::NIB_W] =
          {ddrdp_pkg::NIB_W{!(i == 0 ? n0 : n1)}};
      end
    end else begin
      for (int i = 0; i < ddrdp_pkg::NUM_LANES; i++) begin
        if (i * ddrdp_pkg::LANE_W < DATA_W) begin
          m[i*ddrdp_pkg::LANE_W +: ddrdp_pkg::LANE_W] =
            {ddrdp_pkg::LANE_W{!bsel_n[i]}};
        end
      end
    end
    return m;
  endfunction

  // Second-word address: inversion of the seed bit for x18 and x36, so it wraps within the pair.
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] r;
    r = a;
    if (DATA_W > ddrdp_pkg::LANE_W) begin
      r[0] = !a[0];
    end
    return r;
  endfunction

  assign cmd.load_n      = cycle_load_n_i;
  assign cmd.read_nwrite = read_nwrite_i;
  assign cmd.addr        = AW'(addr_i);

  // Read launch edges follow C/C-bar, or K/K-bar in single clock mode.
  assign launch  = single_clk_i ? (k_rise_i || kn_rise_i)
                                : (c_rise_i || cn_rise_i);
  assign capture = k_rise_i || kn_rise_i;

  always_comb begin
    logic [MW-1:0] m;
    logic [ADDR_W-1:0] seed;
    nxt_st = st_ff;
    m      = beat_mask(nibble_sel_n0_i, nibble_sel_n1_i,
                       {byte_sel_n3_i, byte_sel_n2_i, byte_sel_n1_i, byte_sel_n0_i});
    seed   = ADDR_W'(cmd.addr);
    if (DATA_W <= ddrdp_pkg::LANE_W) begin
      seed[0] = 1'b0;
    end
    wr_push       = 1'b0;
    wr_beat       = '0;
    nxt_st.rd_req = 1'b0;
    unique case (st_ff.phase)
      ddrdp_pkg::DDRDP_IDLE: begin
        nxt_st.dq_oe = 1'b0;
        if (k_rise_i && !cmd.load_n) begin
          nxt_st.beat = 1'b0;
          nxt_st.addr = seed;
          if (cmd.read_nwrite) begin
            nxt_st.phase   = ddrdp_pkg::DDRDP_RD_BEAT;
            nxt_st.rd_req  = 1'b1;
            nxt_st.rd_addr = seed;
          end else begin
            nxt_st.phase = ddrdp_pkg::DDRDP_WR_BEAT;
          end
        end
      end
      ddrdp_pkg::DDRDP_WR_BEAT: begin
        if (capture && fifo_ready) begin
          wr_push             = 1'b1;
          wr_beat.addr        = AW'(st_ff.addr);
          wr_beat.data        = MW'(dq_in_i);
          wr_beat.bit_en      = m & MW'({DATA_W{1'b1}});
          nxt_st.addr         = next_addr(st_ff.addr);
          nxt_st.beat         = !st_ff.beat;
          if (st_ff.beat) begin
            nxt_st.phase = ddrdp_pkg::DDRDP_IDLE;
          end
        end
      end
      ddrdp_pkg::DDRDP_RD_BEAT: begin
        if (launch) begin
          nxt_st.dq_out = rd_data_i;
          nxt_st.dq_oe  = 1'b1;
          nxt_st.addr   = next_addr(st_ff.addr);
          nxt_st.beat   = !st_ff.beat;
          if (!st_ff.beat) begin
            nxt_st.rd_req  = 1'b1;
            nxt_st.rd_addr = next_addr(st_ff.addr);
          end else begin
            nxt_st.phase = ddrdp_pkg::DDRDP_IDLE;
          end
        end
      end
      default: begin
        nxt_st.phase = ddrdp_pkg::DDRDP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Beats enter the FIFO in their capture cycle, so the room seen by the capture test is exact.
  // A registered push could meet a FIFO that filled meanwhile and lose the beat.
  ddrdp_fifo #(
    .WIDTH (BW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (wr_push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (wr_beat),
    .out_valid_o (fifo_valid),
    .out_ready_i (wr_ready_i),
    .out_data_o  (fifo_out)
  );

  assign dq_out_o    = st_ff.dq_out;
  assign dq_oe_o     = st_ff.dq_oe;
  assign wr_valid_o  = fifo_valid;
  assign wr_addr_o   = ADDR_W'(fifo_out.addr);
  assign wr_data_o   = DATA_W'(fifo_out.data);
  assign wr_bit_en_o = DATA_W'(fifo_out.bit_en);
  assign rd_req_o    = st_ff.rd_req;
  assign rd_addr_o   = st_ff.rd_addr;
  assign busy_o      = (st_ff.phase != ddrdp_pkg::DDRDP_IDLE);
endmodule

// ---- verilog/ddrdp_pkg.sv ----
// Purpose: Shared constants and carrier structs for the DDR SRAM data port.
// Assumes: One system clock; K and its complement arrive as phase strobes.
// Notes:   Widths are module parameters; constants here are fixed figures.
package ddrdp_pkg;
  localparam int unsigned MAX_W       = 36;
  localparam int unsigned LANE_W      = 9;
  localparam int unsigned NIB_W       = 4;
  localparam int unsigned NUM_LANES   = 4;
  localparam int unsigned NUM_NIBS    = 2;
  localparam int unsigned X8_W        = 8;
  localparam int unsigned BURST_LEN   = 2;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned ADDR_W      = 20;

  // Control captured at the start of a transaction.
  typedef struct packed {
    logic              load_n;
    logic              read_nwrite;
    logic [ADDR_W-1:0] addr;
  } ddrdp_cmd_s;

  // One write beat as it leaves the port towards the array.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [MAX_W-1:0]  data;
    logic [MAX_W-1:0]  bit_en;
  } ddrdp_wbeat_s;

  typedef enum logic [1:0] {
    DDRDP_IDLE,
    DDRDP_WR_BEAT,
    DDRDP_RD_BEAT
  } ddrdp_phase_e;
endpackage

// ---- verilog/ddrdp_fifo.sv ----
// Purpose: Parameterised valid/ready FIFO for write beats.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Full and empty are exact; ready drops when full.
`timescale 1ns/1ps
module ddrdp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0]   cnt;
  } ddrdp_fifo_s;

  logic [WIDTH-1:0] mem [DEPTH];
  ddrdp_fifo_s      st_ff;
  ddrdp_fifo_s      nxt_st;
  logic             push;
  logic             pop;

  assign in_ready_o  = (st_ff.cnt != (PW+1)'(DEPTH));
  assign out_valid_o = (st_ff.cnt != '0);
  assign out_data_o  = mem[st_ff.rd];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.wr = (st_ff.wr == PW'(DEPTH-1)) ? '0 : st_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_st.rd = (st_ff.rd == PW'(DEPTH-1)) ? '0 : st_ff.rd + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[st_ff.wr] <= in_data_i;
    end
  end
endmodule

// ---- testbench/ddrdp_port_properties.sv ----
// Purpose: Concurrent checks on the pins of the data port.
// Assumes: Strobe pulses are one clk wide.
// Notes:   Bound to ddrdp_port from the testbench top file.
`timescale 1ns/1ps
module ddrdp_port_properties #(
  parameter int unsigned DATA_W = 36
) (
  input wire logic              clk_i,
  input wire logic              nrst_i,
  input wire logic              k_rise_i,
  input wire logic              kn_rise_i,
  input wire logic              c_rise_i,
  input wire logic              cn_rise_i,
  input wire logic              single_clk_i,
  input wire logic              cycle_load_n_i,
  input wire logic              read_nwrite_i,
  input wire logic [DATA_W-1:0] dq_out_o,
  input wire logic              dq_oe_o,
  input wire logic              wr_valid_o,
  input wire logic [DATA_W-1:0] wr_bit_en_o,
  input wire logic              rd_req_o,
  input wire logic              busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic launch;
  logic lanes_ok;
  assign launch = single_clk_i ? (k_rise_i | kn_rise_i) : (c_rise_i | cn_rise_i);
  always_comb begin
    lanes_ok = 1'b1;
    for (int i = 0; i < DATA_W / 9; i++) begin
      lanes_ok = lanes_ok & ((wr_bit_en_o[i*9 +: 9] == '0) | (&wr_bit_en_o[i*9 +: 9]));
    end
  end
  chk_load_read: assert property (
    k_rise_i && !cycle_load_n_i && read_nwrite_i && !busy_o |=> rd_req_o && busy_o)
    else $error("read load gave no request");
  chk_load_write: assert property (
    k_rise_i && !cycle_load_n_i && !read_nwrite_i && !busy_o |=> busy_o && !rd_req_o)
    else $error("write load not taken");
  chk_no_load: assert property (
    !busy_o && !(k_rise_i && !cycle_load_n_i) |=> !busy_o)
    else $error("transaction started without load");
  chk_oe_idle: assert property (!busy_o [*2] |-> !dq_oe_o)
    else $error("data driven while idle");
  chk_oe_source: assert property ($rose(dq_oe_o) |-> $past(launch))
    else $error("output enabled without launch strobe");
  chk_dq_hold: assert property (
    dq_oe_o && $past(dq_oe_o) && !$past(launch) |-> $stable(dq_out_o))
    else $error("read data moved without launch strobe");
  chk_req_pulse: assert property (rd_req_o |=> !rd_req_o)
    else $error("read request longer than one cycle");
  chk_lane_mask: assert property (wr_valid_o |-> lanes_ok)
    else $error("byte lane partly enabled");
endmodule

// ---- testbench/ddrdp_array_model.sv ----
// Purpose: Storage array behind the port's write FIFO and read path.
// Assumes: Only the low four address bits are decoded.
// Notes:   stall_i holds off write beats so the FIFO fills.
`timescale 1ns/1ps
module ddrdp_array_model (
  input  wire logic        clk_i,
  input  wire logic        stall_i,
  input  wire logic        wr_valid_i,
  output logic             wr_ready_o,
  input  wire logic [19:0] wr_addr_i,
  input  wire logic [35:0] wr_data_i,
  input  wire logic [35:0] wr_bit_en_i,
  input  wire logic [19:0] rd_addr_i,
  output logic      [35:0] rd_data_o
);
  logic [35:0] mem [16];
  initial foreach (mem[i]) mem[i] = 36'h0_0000_0000;
  assign wr_ready_o = !stall_i;
  assign rd_data_o  = mem[rd_addr_i[3:0]];
  // Bits without enable keep their stored value.
  always @(posedge clk_i) begin
    if (wr_valid_i && wr_ready_o) begin
      mem[wr_addr_i[3:0]] <= (mem[wr_addr_i[3:0]] & ~wr_bit_en_i) | (wr_data_i & wr_bit_en_i);
    end
  end
endmodule

// ---- testbench/test_ddrdp_port.sv ----
// Purpose: Self-checking bench for the x36 and x8 data ports.
// Assumes: Controller strobes are driven 1 ns after clk_i rises.
// Notes:   Expected array contents are kept in exp_mem (x36) and exp8 (x8).
`timescale 1ns/1ps
module test_ddrdp_port;
  localparam logic [35:0] ZERO = 36'h0_0000_0000;
  localparam logic [35:0] ONE  = 36'h0_0000_0001;
  logic        clk_i, nrst_i, k, kn, c, cn, sc, ld_n, rnw, stall;
  logic        dq_oe, wr_valid, wr_ready, rd_req, busy;
  logic [3:0]  bs_n;
  logic [19:0] a, wr_addr, rd_addr;
  logic [35:0] dq, dq_out, rd_data, wr_data, wr_en;
  logic [35:0] exp_mem [16];
  logic        dq8_oe, wr8_valid, wr8_ready, busy8;
  logic [7:0]  dq8_out, wr8_data, wr8_en;
  logic [7:0]  exp8 [16];
  logic [19:0] wr8_addr, rd8_addr;
  logic [35:0] rd8_data;
  int          bad_count = 0;
  int          compares = 0;
  ddrdp_port dut (.clk_i, .nrst_i, .k_rise_i(k), .kn_rise_i(kn), .c_rise_i(c),
    .cn_rise_i(cn), .single_clk_i(sc), .cycle_load_n_i(ld_n), .read_nwrite_i(rnw),
    .addr_i(a), .nibble_sel_n0_i(1'b1), .nibble_sel_n1_i(1'b1), .byte_sel_n0_i(bs_n[0]),
    .byte_sel_n1_i(bs_n[1]), .byte_sel_n2_i(bs_n[2]), .byte_sel_n3_i(bs_n[3]),
    .dq_in_i(dq), .dq_out_o(dq_out), .dq_oe_o(dq_oe), .wr_valid_o(wr_valid),
    .wr_ready_i(wr_ready), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .wr_bit_en_o(wr_en),
    .rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_data_i(rd_data), .busy_o(busy));
  ddrdp_array_model u_array (.clk_i, .stall_i(stall), .wr_valid_i(wr_valid),
    .wr_ready_o(wr_ready), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
    .wr_bit_en_i(wr_en), .rd_addr_i(rd_addr), .rd_data_o(rd_data));
  // The x8 port shares the controller pins; the low two byte selects act as nibble selects.
  ddrdp_port #(.DATA_W(8)) dut8 (.clk_i, .nrst_i, .k_rise_i(k), .kn_rise_i(kn),
    .c_rise_i(c), .cn_rise_i(cn), .single_clk_i(sc), .cycle_load_n_i(ld_n),
    .read_nwrite_i(rnw), .addr_i(a), .nibble_sel_n0_i(bs_n[0]), .nibble_sel_n1_i(bs_n[1]),
    .byte_sel_n0_i(1'b1), .byte_sel_n1_i(1'b1), .byte_sel_n2_i(1'b1), .byte_sel_n3_i(1'b1),
    .dq_in_i(dq[7:0]), .dq_out_o(dq8_out), .dq_oe_o(dq8_oe), .wr_valid_o(wr8_valid),
    .wr_ready_i(wr8_ready), .wr_addr_o(wr8_addr), .wr_data_o(wr8_data),
    .wr_bit_en_o(wr8_en), .rd_req_o(), .rd_addr_o(rd8_addr), .rd_data_i(rd8_data[7:0]),
    .busy_o(busy8));
  ddrdp_array_model u_array8 (.clk_i, .stall_i(stall), .wr_valid_i(wr8_valid),
    .wr_ready_o(wr8_ready), .wr_addr_i(wr8_addr), .wr_data_i({28'h0, wr8_data}),
    .wr_bit_en_i({28'h0, wr8_en}), .rd_addr_i(rd8_addr), .rd_data_o(rd8_data));
  task automatic complete_run();
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input logic [3:0] s);
    {k, kn, c, cn} = s;
    @(posedge clk_i);
    #1;
  endtask
  function automatic logic [35:0] mix(input logic [35:0] o, n, input logic [3:0] m_n);
    for (int i = 0; i < 4; i++) begin
      if (!m_n[i]) o[i*9 +: 9] = n[i*9 +: 9];
    end
    return o;
  endfunction
  function automatic logic [7:0] nmix(input logic [7:0] o, n, input logic [1:0] m_n);
    for (int i = 0; i < 2; i++) begin
      if (!m_n[i]) o[i*4 +: 4] = n[i*4 +: 4];
    end
    return o;
  endfunction
  task automatic wr(input logic [19:0] ad, input logic [35:0] d0, d1,
                    input logic [3:0] m0, m1);
    exp_mem[ad[3:0]] = mix(exp_mem[ad[3:0]], d0, m0);
    exp_mem[ad[3:0] ^ 4'h1] = mix(exp_mem[ad[3:0] ^ 4'h1], d1, m1);
    // In x8 both beats land on the even address, the second over the first.
    exp8[{ad[3:1], 1'b0}] = nmix(nmix(exp8[{ad[3:1], 1'b0}], d0[7:0], m0[1:0]),
                                 d1[7:0], m1[1:0]);
    {ld_n, rnw, a} = {2'b00, ad};
    cyc(4'h8);
    {ld_n, rnw, dq, bs_n} = {2'b11, d0, m0};
    cyc(4'h4);
    {dq, bs_n} = {d1, m1};
    cyc(4'h8);
    {dq, bs_n} = {~d1, 4'h0};
    cyc(4'h0);
    repeat (20) if (busy) cyc(4'h0);
    check("write busy", ZERO, {35'h0, busy});
    check("x8 write busy", ZERO, {35'h0, busy8});
  endtask
  task automatic rd(input logic [19:0] ad, input logic s1);
    sc = s1;
    {ld_n, rnw, a} = {2'b01, ad};
    cyc(4'h8);
    // When s1 is low, a second load while busy must be ignored.
    {rnw, a} = {1'b0, ~ad};
    cyc(s1 ? 4'h0 : 4'h8);
    ld_n = 1'b1;
    cyc(s1 ? 4'h8 : 4'h2);
    check("read word0", exp_mem[ad[3:0]], dq_out);
    check("read oe", ONE, {35'h0, dq_oe});
    check("x8 word0", {28'h0, exp8[{ad[3:1], 1'b0}]}, {28'h0, dq8_out});
    check("x8 oe", ONE, {35'h0, dq8_oe});
    cyc(4'h0);
    cyc(s1 ? 4'h4 : 4'h1);
    check("read word1", exp_mem[ad[3:0] ^ 4'h1], dq_out);
    check("x8 word1", {28'h0, exp8[{ad[3:1], 1'b0}]}, {28'h0, dq8_out});
    cyc(4'h0);
    cyc(4'h0);
    check("read oe off", ZERO, {35'h0, dq_oe});
    sc = 1'b0;
  endtask
  task automatic sc_masks();
    wr(20'h0_0004, 36'h1_2345_6789, 36'hF_EDCB_A987, 4'h0, 4'h0);
    wr(20'h0_0004, 36'hA_AAAA_AAAA, 36'h5_5555_5555, 4'h5, 4'hA);
    rd(20'h0_0004, 1'b0);
    wr(20'h0_0007, 36'h3_C3C3_C3C3, 36'h6_9696_9696, 4'h3, 4'hC);
    rd(20'h0_0007, 1'b0);
    rd(20'h0_0006, 1'b1);
  endtask
  task automatic sc_fifo();
    stall = 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr(20'(i * 2), {9{i[3:0]}}, ~{9{i[3:0]}}, i[3:0], ~i[3:0]);
    end
    check("fifo holds", ONE, {35'h0, wr_valid});
    stall = 1'b0;
    repeat (40) cyc(4'h0);
    for (int i = 0; i < 8; i++) begin
      rd(20'(i * 2), i[0]);
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    complete_run();
  end
  initial begin
    {nrst_i, k, kn, c, cn, sc, ld_n, rnw, stall} = 9'h004;
    {a, dq, bs_n} = {20'h0_0000, ZERO, 4'hF};
    foreach (exp_mem[i]) exp_mem[i] = ZERO;
    foreach (exp8[i]) exp8[i] = 8'h00;
    repeat (20) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    sc_masks();
    sc_fifo();
    complete_run();
  end
endmodule
bind ddrdp_port ddrdp_port_properties #(.DATA_W(DATA_W)) u_chk (.clk_i, .nrst_i,
  .k_rise_i, .kn_rise_i, .c_rise_i, .cn_rise_i, .single_clk_i, .cycle_load_n_i,
  .read_nwrite_i, .dq_out_o, .dq_oe_o, .wr_valid_o, .wr_bit_en_o, .rd_req_o, .busy_o);
